// ===== design/rwdt_defines.svh
`ifndef RWDT_DEFINES_SVH
`define RWDT_DEFINES_SVH

// Register byte addresses
`define RWDT_MODE_ADDR 32'hfffff090
`define RWDT_CMD_ADDR 32'hfffff094
`define RWDT_STAT_ADDR 32'hfffff098

// Mode register field positions
`define RWDT_RUN_BIT 7
`define RWDT_SEL_HI 6
`define RWDT_SEL_LO 5
`define RWDT_IDLE_BIT 2
`define RWDT_ROUTE_BIT 1

// Status register field positions
`define RWDT_STAT_FLAG_BIT 0
`define RWDT_STAT_HOLD_BIT 1
`define RWDT_STAT_RUN_BIT 2

// Reset values
`define RWDT_RUN_RESET 1'b1
`define RWDT_SEL_RESET 2'h0
`define RWDT_IDLE_RESET 1'b0
`define RWDT_ROUTE_RESET 1'b0

// Command codes
`define RWDT_DISABLE_CODE 8'hb1
`define RWDT_CLEAR_CODE 8'h3c

// Counter geometry
`define RWDT_STAGES 22
`define RWDT_TAP_BASE 15
`define RWDT_TAP_STEP 2

// Reset hold timing: one state is two clock periods
`define RWDT_RESET_STATES 32
`define RWDT_HCLK_PER_STATE 2
`define RWDT_HOLD_CYCLES (`RWDT_RESET_STATES * `RWDT_HCLK_PER_STATE)
`define RWDT_HOLD_W 7

`endif

// ===== design/rwdt_pkg.sv
package rwdt_pkg;

    // Software-visible mode fields
    typedef struct packed {
        logic run_enable;
        logic [1:0] detect_period_sel;
        logic idle_run_select;
        logic overflow_reset_route;
    } rwdt_mode_type;

    // Captured AHB address phase
    typedef struct packed {
        logic sel_mode;
        logic sel_cmd;
        logic write;
    } rwdt_aphase_type;

    // Outputs toward the interrupt controller and reset logic
    typedef struct packed {
        logic runaway_nmi;
        logic runaway_nmi_flag;
        logic chip_reset_req;
        logic clock_gear_div8;
    } rwdt_event_type;

    // Overflow handling state
    typedef enum logic {
        rwdt_st_run,
        rwdt_st_hold
    } rwdt_state_type;

endpackage

// ===== design/rwdt_counter.sv
`timescale 1ns/10ps
`include "rwdt_defines.svh"

module rwdt_counter (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control
    input wire logic run,
    input wire logic clear,
    input wire logic [1:0] detect_period_sel,
    // Event
    output logic overflow
);
    import rwdt_pkg::*;

    logic half; // Half-rate phase
    logic [`RWDT_STAGES-1:0] count; // Stage outputs
    logic [3:0] tap_bits; // Selectable taps
    logic tap_hit; // Chosen tap reached

    // Half-rate advance phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            half <= 1'b0;
        end else if (clear) begin
            half <= 1'b0;
        end else if (run) begin
            half <= ~half;
        end
    end

    // Tap picks at 2^15, 2^17, 2^19, 2^21
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gen_tap
            assign tap_bits[g] = count[`RWDT_TAP_BASE + `RWDT_TAP_STEP * g];
        end
    endgenerate

    assign tap_hit = tap_bits[detect_period_sel];

    // Twenty-two stage binary count on the half-rate tick
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= '0;
        end else if (clear || tap_hit) begin
            // Restart after overflow or clear
            count <= '0;
        end else if (run && half) begin
            count <= count + `RWDT_STAGES'(1);
        end
    end

    // One-cycle overflow event
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overflow <= 1'b0;
        end else begin
            overflow <= tap_hit;
        end
    end

endmodule // rwdt_counter

// ===== design/rwdt_top.sv
`timescale 1ns/10ps
`include "rwdt_defines.svh"

// Function
// - Twenty-two binary stages on half-rate clock
// - Period field picks one of four taps
// - Overflow raises NMI and sets source flag
// - Overflow may reset whole chip instead
// - Chip reset held for 32 states
// - Clock gear divides by eight during reset
// - Bypass pin keeps being sampled in reset
// - Mode register and command register exist
// - Period field two bits, resets to 00
// - Run enable resets to one
// - Stop needs enable cleared plus code B1
// - Setting run enable alone restarts watchdog
// - Routing bit resets to NMI selection
module rwdt_top (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Chip environment
    input wire logic cpu_idle,
    input wire logic nmi_flag_clear,
    input wire logic pll_bypass_pin,
    // Events and reset control
    output rwdt_pkg::rwdt_event_type events,
    output logic pll_bypass_level
);
    import rwdt_pkg::*;

    rwdt_aphase_type aphase; // Pending data phase
    rwdt_mode_type mode; // Mode register
    rwdt_state_type state; // Overflow state
    rwdt_state_type next_state; // Next overflow state
    logic counting; // Watchdog enabled
    logic [`RWDT_HOLD_W-1:0] hold_cnt; // Reset hold counter
    logic overflow; // Counter overflow pulse
    logic take; // Address phase accepted
    logic mode_wr; // Mode write data phase
    logic cmd_wr; // Command write data phase
    logic [7:0] wbyte; // Written low byte
    logic cmd_disable; // Disable code seen
    logic cmd_clear; // Clear code seen
    logic idle_pause; // Paused in idle
    logic run; // Counter advance gate
    logic hold_done; // Last hold cycle
    logic [31:0] next_hrdata; // Read data mux
    logic [7:0] mode_rd; // Mode read image
    logic [7:0] stat_rd; // Status read image
    logic holding; // Chip reset hold in force
    logic restart; // Counter restart request
    logic nmi_pulse; // Interrupt route pulse
    logic nmi_src_flag; // Sticky source flag
    logic reset_req; // Internal chip reset request
    logic gear_req; // Clock gear divide request

    // Address phase accepted on any NONSEQ or SEQ transfer
    assign take = hsel && hready && htrans[1];

    // Capture the address phase for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Nothing pending after reset
            aphase <= '0;
        end else if (take) begin
            // Decode the target now, act on it in the data phase
            aphase.sel_mode <= (haddr == `RWDT_MODE_ADDR);
            aphase.sel_cmd <= (haddr == `RWDT_CMD_ADDR);
            aphase.write <= hwrite;
        end else if (hready) begin
            // Idle cycle: nothing pending
            aphase <= '0;
        end
    end

    // Data phase write strobes, low byte lane only
    assign wbyte = hwdata[7:0];
    assign mode_wr = aphase.write && aphase.sel_mode;
    assign cmd_wr = aphase.write && aphase.sel_cmd;

    // Command decode; unknown codes fall through unused
    assign cmd_disable = cmd_wr && (wbyte == `RWDT_DISABLE_CODE);
    assign cmd_clear = cmd_wr && (wbyte == `RWDT_CLEAR_CODE);

    // Zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Ready straight out of reset
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            // Never stretches a transfer, never errors
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Mode register, restored by bus reset and by own chip reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Bus reset values
            mode.run_enable <= `RWDT_RUN_RESET;
            mode.detect_period_sel <= `RWDT_SEL_RESET;
            mode.idle_run_select <= `RWDT_IDLE_RESET;
            mode.overflow_reset_route <= `RWDT_ROUTE_RESET;
        end else if (holding) begin
            // Internal chip reset also reinitialises the fields
            mode.run_enable <= `RWDT_RUN_RESET;
            mode.detect_period_sel <= `RWDT_SEL_RESET;
            mode.idle_run_select <= `RWDT_IDLE_RESET;
            mode.overflow_reset_route <= `RWDT_ROUTE_RESET;
        end else if (mode_wr) begin
            // Software write of the low byte
            mode.run_enable <= wbyte[`RWDT_RUN_BIT];
            mode.detect_period_sel <= wbyte[`RWDT_SEL_HI:`RWDT_SEL_LO];
            mode.idle_run_select <= wbyte[`RWDT_IDLE_BIT];
            mode.overflow_reset_route <= wbyte[`RWDT_ROUTE_BIT];
        end
    end

    // Enable state: clearing the bit alone does not stop counting
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Counting from the first cycle
            counting <= 1'b1;
        end else if (holding) begin
            // Comes out of chip reset counting
            counting <= 1'b1;
        end else if (mode_wr && wbyte[`RWDT_RUN_BIT]) begin
            // Writing one re-enables with no code
            counting <= 1'b1;
        end else if (cmd_disable && !mode.run_enable) begin
            // Both halves of the disable sequence present
            counting <= 1'b0;
        end
    end

    // Idle pause unless idle running is selected
    assign idle_pause = cpu_idle && !mode.idle_run_select;

    // Counter runs only while enabled and not holding reset
    assign run = counting && !idle_pause && (state == rwdt_st_run);

    // Clear code or hold both restart the period from zero
    assign restart = cmd_clear || holding;

    // Prescaler and tap selection
    rwdt_counter u_counter (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(run),
        .clear(restart),
        .detect_period_sel(mode.detect_period_sel),
        .overflow(overflow)
    );

    // Last cycle of the reset hold
    assign hold_done = (hold_cnt == `RWDT_HOLD_W'(`RWDT_HOLD_CYCLES - 1));

    // Overflow routing decision
    always_comb begin
        // Stay put unless a transition fires
        next_state = state;
        case (state)
            rwdt_st_run: begin
                // Reset route enters the hold
                if (overflow && mode.overflow_reset_route) begin
                    next_state = rwdt_st_hold;
                end
            end
            rwdt_st_hold: begin
                // Release after 32 states
                if (hold_done) begin
                    next_state = rwdt_st_run;
                end
            end
            default: begin
                // Unused encodings fall back to running
                next_state = rwdt_st_run;
            end
        endcase
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Start in normal running
            state <= rwdt_st_run;
        end else begin
            // Advance every clock
            state <= next_state;
        end
    end

    // Hold flag shared by mode, enable, counter and status
    assign holding = (state == rwdt_st_hold);

    // Hold duration counter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_cnt <= '0;
        end else if (holding) begin
            // Count clock periods of the hold
            hold_cnt <= hold_cnt + `RWDT_HOLD_W'(1);
        end else begin
            // Ready for the next hold
            hold_cnt <= '0;
        end
    end

    // Internal chip reset request, high for the whole hold
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // No request out of reset
            reset_req <= 1'b0;
        end else begin
            // Taken from the next state so it lines up with the hold
            reset_req <= (next_state == rwdt_st_hold);
        end
    end

    // Clock gear divide request, same timing as the chip reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Full speed out of reset
            gear_req <= 1'b0;
        end else begin
            // Slow clock while the hold is in force
            gear_req <= (next_state == rwdt_st_hold);
        end
    end

    // Non-maskable interrupt pulse on the interrupt route
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Quiet out of reset
            nmi_pulse <= 1'b0;
        end else begin
            // One cycle per overflow unless routed to reset
            nmi_pulse <= overflow && !mode.overflow_reset_route;
        end
    end

    // Source flag: set wins over the controller's clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Clear out of reset
            nmi_src_flag <= 1'b0;
        end else if (overflow && !mode.overflow_reset_route) begin
            // Overflow on the interrupt route marks the source
            nmi_src_flag <= 1'b1;
        end else if (nmi_flag_clear) begin
            // Interrupt controller acknowledges the source
            nmi_src_flag <= 1'b0;
        end
    end

    // Event word gathered from the flops above; one process drives it all
    always_comb begin
        events.runaway_nmi = nmi_pulse;
        events.runaway_nmi_flag = nmi_src_flag;
        events.chip_reset_req = reset_req;
        events.clock_gear_div8 = gear_req;
    end

    // Bypass pin sampled every cycle, hold included
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Assume the pin's fixed high level until sampled
            pll_bypass_level <= 1'b1;
        end else begin
            // Sampling goes on through a watchdog hold as well
            pll_bypass_level <= pll_bypass_pin;
        end
    end

    // Mode read image; unused bits read zero
    always_comb begin
        // Spare bits stay zero
        mode_rd = 8'h00;
        mode_rd[`RWDT_RUN_BIT] = mode.run_enable;
        mode_rd[`RWDT_SEL_HI:`RWDT_SEL_LO] = mode.detect_period_sel;
        mode_rd[`RWDT_IDLE_BIT] = mode.idle_run_select;
        mode_rd[`RWDT_ROUTE_BIT] = mode.overflow_reset_route;
    end

    // Status read image
    always_comb begin
        stat_rd = 8'h00;
        stat_rd[`RWDT_STAT_FLAG_BIT] = events.runaway_nmi_flag;
        stat_rd[`RWDT_STAT_HOLD_BIT] = holding;
        stat_rd[`RWDT_STAT_RUN_BIT] = counting;
    end

    // Read mux at address phase; command and unmapped read zero
    always_comb begin
        next_hrdata = 32'h00000000;
        if (take && !hwrite) begin
            // Only a read address phase loads data
            case (haddr)
                `RWDT_MODE_ADDR: begin
                    // Mode fields in the low byte
                    next_hrdata = {24'h000000, mode_rd};
                end
                `RWDT_STAT_ADDR: begin
                    // Flag, hold and enable state
                    next_hrdata = {24'h000000, stat_rd};
                end
                default: begin
                    // Command register and holes
                    next_hrdata = 32'h00000000;
                end
            endcase
        end
    end

    // Registered read data for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Bus idle value
            hrdata <= 32'h00000000;
        end else begin
            // Stands for the data phase only
            hrdata <= next_hrdata;
        end
    end

endmodule // rwdt_top

// ===== sim/rwdt_chk.sv
`timescale 1ns/10ps
`include "rwdt_defines.svh"

module rwdt_chk (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Environment and events
    input wire logic nmi_flag_clear,
    input wire logic pll_bypass_pin,
    input wire rwdt_pkg::rwdt_event_type events,
    input wire logic pll_bypass_level
);
    import rwdt_pkg::*;
    logic [6:0] hold_cnt; // Hold cycles seen so far
    logic rd_req; // Read taken at this edge
    assign rd_req = hsel && hready && htrans[1] && !hwrite;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Length of the running hold
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_cnt <= 7'h00;
        end else begin
            hold_cnt <= events.chip_reset_req ? hold_cnt + 7'h01 : 7'h00;
        end
    end
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready");
    a_rdata_idle: assert property (!rd_req |=> hrdata == 32'h0) else $error("stray read data");
    a_mode_bits: assert property (rd_req && haddr == `RWDT_MODE_ADDR
        |=> (hrdata & 32'hffffff19) == 32'h0) else $error("mode spare bits set");
    a_cmd_read: assert property (rd_req && haddr == `RWDT_CMD_ADDR
        |=> hrdata == 32'h0) else $error("command read not zero");
    a_nmi_pulse: assert property (events.runaway_nmi |=> !events.runaway_nmi)
        else $error("nmi longer than one cycle");
    a_nmi_flag: assert property (events.runaway_nmi |-> events.runaway_nmi_flag)
        else $error("nmi without flag");
    a_flag_sticky: assert property (events.runaway_nmi_flag && !nmi_flag_clear
        |=> events.runaway_nmi_flag) else $error("flag lost");
    a_flag_clear: assert property (events.runaway_nmi_flag && nmi_flag_clear
        |=> !events.runaway_nmi_flag || events.runaway_nmi) else $error("flag not cleared");
    a_gear_match: assert property (events.clock_gear_div8 == events.chip_reset_req)
        else $error("gear and hold differ");
    a_hold_len: assert property ($fell(events.chip_reset_req) |-> hold_cnt == 7'h40)
        else $error("hold length wrong");
    a_hold_max: assert property (events.chip_reset_req |-> hold_cnt < 7'h40)
        else $error("hold too long");
    a_bypass_follow: assert property ($past(hresetn)
        |-> pll_bypass_level == $past(pll_bypass_pin)) else $error("bypass level stale");
    c_nmi: cover property (events.runaway_nmi);
    c_hold: cover property ($rose(events.chip_reset_req));
    c_flag_clear: cover property (events.runaway_nmi_flag && nmi_flag_clear);
endmodule // rwdt_chk

bind rwdt_top rwdt_chk chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .nmi_flag_clear(nmi_flag_clear),
    .pll_bypass_pin(pll_bypass_pin), .events(events), .pll_bypass_level(pll_bypass_level));

// ===== sim/runaway_watchdog_timer_bench.sv
`timescale 1ns/10ps
`include "rwdt_defines.svh"

module runaway_watchdog_timer_bench;
    import rwdt_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp; // Bus controls
    logic [31:0] haddr, hwdata, hrdata, rnd, rd; // Bus data and random state
    logic [1:0] htrans; // Transfer type
    logic cpu_idle, nmi_flag_clear, pll_bypass_pin, pll_bypass_level, bypass_high; // Environment
    rwdt_event_type events; // Event outputs
    int num_errors = 0, num_checks = 0, cycles = 0, i; // Counters
    rwdt_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .cpu_idle(cpu_idle), .nmi_flag_clear(nmi_flag_clear),
        .pll_bypass_pin(pll_bypass_pin), .events(events),
        .pll_bypass_level(pll_bypass_level));
    // Clock
    always #2.5 hclk = ~hclk;
    // Cycle count, hang limit and changing bypass pin
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        pll_bypass_pin <= bypass_high | (cycles[0] ^ cycles[2]);
        if (cycles == 150000) begin
            num_errors++;
            end_sim;
        end
    end
    // Next random word
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // Readable mode bits of a written word
    function automatic logic [31:0] exp_mode(input logic [31:0] v);
        return v & 32'he6;
    endfunction
    // Verdict
    task end_sim;
        if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Value compare
    task check_val(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One single transfer, entered just after an edge
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk iff hreadyout === 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk iff hreadyout === 1'b1);
        r = hrdata;
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, rd);
    endtask
    task rd_check(input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, rd);
        check_val(rd, exp);
    endtask
    // Main sequence
    initial begin
        {hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        {cpu_idle, nmi_flag_clear, pll_bypass_pin, bypass_high} = '0;
        rnd = 32'd5883;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_check(`RWDT_MODE_ADDR, 32'h80);
        rd_check(`RWDT_CMD_ADDR, 32'h0);
        rd_check(`RWDT_STAT_ADDR, 32'h4);
        rd_check(`RWDT_MODE_ADDR + 32'h10, 32'h0);
        // Random mode values and stray command codes
        for (i = 0; i < 20; i++) begin
            rnd = xorshift(rnd);
            cpu_idle <= rnd[8];
            wr(`RWDT_MODE_ADDR, rnd);
            rd_check(`RWDT_MODE_ADDR, exp_mode(rnd));
            wr(`RWDT_CMD_ADDR, {24'h0, rnd[23:16] ^ {7'h0, rnd[23:16] == 8'hb1
                || rnd[23:16] == 8'h3c}});
            rd_check(`RWDT_STAT_ADDR, 32'h4);
        end
        cpu_idle <= 1'b0;
        // Disable needs both writes, enable needs one
        wr(`RWDT_MODE_ADDR, 32'h80);
        wr(`RWDT_CMD_ADDR, 32'hb1);
        rd_check(`RWDT_STAT_ADDR, 32'h4);
        wr(`RWDT_MODE_ADDR, 32'h0);
        wr(`RWDT_CMD_ADDR, 32'hb1);
        rd_check(`RWDT_STAT_ADDR, 32'h0);
        // Idle only while the watchdog is stopped
        cpu_idle <= 1'b1;
        rd_check(`RWDT_STAT_ADDR, 32'h0);
        cpu_idle <= 1'b0;
        wr(`RWDT_MODE_ADDR, 32'h80);
        rd_check(`RWDT_STAT_ADDR, 32'h4);
        // Interrupt route overflow timed from a clear
        wr(`RWDT_CMD_ADDR, 32'h3c);
        // An idle pause of 100 cycles delays the overflow by as much
        cpu_idle <= 1'b1;
        repeat (100) @(posedge hclk);
        cpu_idle <= 1'b0;
        for (i = 0; i < 70000 && events.runaway_nmi !== 1'b1; i++) @(posedge hclk);
        check_val(i >= 65530 && i <= 65545, 32'h1);
        rd_check(`RWDT_STAT_ADDR, 32'h5);
        nmi_flag_clear <= 1'b1;
        @(posedge hclk);
        nmi_flag_clear <= 1'b0;
        rd_check(`RWDT_STAT_ADDR, 32'h4);
        // Reset route overflow
        // Bypass pin held high from here, through the hold
        bypass_high <= 1'b1;
        wr(`RWDT_MODE_ADDR, 32'h82);
        wr(`RWDT_CMD_ADDR, 32'h3c);
        for (i = 0; i < 70000 && events.chip_reset_req !== 1'b1; i++) @(posedge hclk);
        for (i = 0; i < 100 && events.chip_reset_req === 1'b1; i++) @(posedge hclk);
        check_val(i, 32'd64);
        rd_check(`RWDT_MODE_ADDR, 32'h80);
        rd_check(`RWDT_STAT_ADDR, 32'h4);
        end_sim;
    end
endmodule // runaway_watchdog_timer_bench
